/* sswl_top.sv */
// sswl_top: sleep-state tracker, wake qualifier, power/message lamp and network lamp repeater.
// assumes wake and link inputs synchronous to clk_sys; software is the power manager.
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module sswl_top
    import sswl_pkg::*;
#(
    parameter int NUM_CH     = 2,
    parameter int BLINK_HALF = SSWL_BLINK_HALF_CYC
) (
    // clock, reset, enable
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire logic                   clk_en,
    // avalon-mm slave
    input  wire logic [SSWL_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    // wake sources
    input  wire logic                   wake_switch,
    input  wire logic                   wake_rtc_alarm,
    input  wire logic                   wake_pme,
    input  wire logic                   wake_lan,
    input  wire logic                   wake_ir,
    input  wire logic                   wake_kbd_mouse,
    input  wire logic                   wake_usb,
    // power controls
    output logic                        cpu_run,
    output logic                        dev_power_en,
    output logic                        port_power_en,
    output logic                        wake_power_en,
    // power and message lamp
    output logic                        lamp_a,
    output logic                        lamp_b,
    // network status
    input  wire logic [NUM_CH-1:0]      net_link,
    input  wire logic [NUM_CH-1:0]      net_speed100,
    input  wire logic [NUM_CH-1:0]      net_activity,
    output logic      [NUM_CH-1:0]      net_led_green,
    output logic      [NUM_CH-1:0]      net_led_yellow
);

    localparam int CNT_W = $clog2(BLINK_HALF + 1);

    if (NUM_CH < 1 || NUM_CH > 12) begin : g_bad_ch
        $error("sswl_top: NUM_CH must be 1 to 12");
    end
    if (BLINK_HALF < 2) begin : g_bad_blink
        $error("sswl_top: BLINK_HALF must be at least 2");
    end

    typedef struct packed {
        sswl_sleep_e              sleep;
        logic                     dual;
        logic                     msg;
        logic [SSWL_WAKE_N-1:0]   wake_seen;
        logic [CNT_W-1:0]         blink_cnt;
        logic                     blink_on;
        logic [NUM_CH-1:0]        act_seen;
        logic [NUM_CH-1:0]        act_show;
        logic                     wait_req;
        logic [31:0]              rdata;
        logic                     cpu;
        logic                     dev;
        logic                     port;
        logic                     wakep;
        logic                     la;
        logic                     lb;
        logic [NUM_CH-1:0]        green;
        logic [NUM_CH-1:0]        yellow;
    } sswl_state_s;

    sswl_state_s st_reg;
    sswl_state_s st_next;

    logic [SSWL_WAKE_N-1:0] wake_raw;
    logic [SSWL_WAKE_N-1:0] wake_ok;
    logic                   accept;
    logic                   commit_wr;

    // wake sources allowed from a given state; nothing wakes a running board
    function automatic logic [SSWL_WAKE_N-1:0] wake_mask(input sswl_sleep_e s);
        unique case (s)
            SSWL_S0: wake_mask = '0;
            SSWL_S1: wake_mask = SSWL_MASK_S1;
            SSWL_S4: wake_mask = SSWL_MASK_S4;
            SSWL_S5: wake_mask = SSWL_MASK_S5;
        endcase
    endfunction

    function automatic logic [31:0] read_mux(input logic [SSWL_ADDR_W-1:0] a,
                                             input sswl_state_s s);
        read_mux = '0;
        unique case (a)
            SSWL_OFF_CTRL: begin
                read_mux[SSWL_CTRL_DUAL] = s.dual;
                read_mux[SSWL_CTRL_MSG]  = s.msg;
            end
            SSWL_OFF_SLEEP: read_mux[1:0] = s.sleep;
            SSWL_OFF_WAKE:  read_mux[SSWL_WAKE_N-1:0] = s.wake_seen;
            SSWL_OFF_LAMP: begin
                read_mux[SSWL_LS_LAMP_A] = s.la;
                read_mux[SSWL_LS_LAMP_B] = s.lb;
                read_mux[SSWL_LS_CPU]    = s.cpu;
                read_mux[SSWL_LS_DEV]    = s.dev;
                read_mux[SSWL_LS_PORT]   = s.port;
                read_mux[SSWL_LS_WAKEP]  = s.wakep;
                for (int c = 0; c < NUM_CH; c++) begin
                    read_mux[SSWL_LS_NET + 2*c]     = s.green[c];
                    read_mux[SSWL_LS_NET + 2*c + 1] = s.yellow[c];
                end
            end
            default: read_mux = '0;
        endcase
    endfunction

    always_comb begin
        wake_raw = '0;
        wake_raw[SSWL_WK_SWITCH] = wake_switch;
        wake_raw[SSWL_WK_RTC]    = wake_rtc_alarm;
        wake_raw[SSWL_WK_PME]    = wake_pme;
        wake_raw[SSWL_WK_LAN]    = wake_lan;
        wake_raw[SSWL_WK_IR]     = wake_ir;
        wake_raw[SSWL_WK_KBD]    = wake_kbd_mouse;
        wake_raw[SSWL_WK_USB]    = wake_usb;
    end

    assign wake_ok   = wake_raw & wake_mask(st_reg.sleep);
    // one-cycle answer: accept while waitrequest high, commit while it is low
    assign accept    = (avs_read | avs_write) & st_reg.wait_req;
    assign commit_wr = avs_write & ~st_reg.wait_req;

    always_comb begin
        st_next = st_reg;

        // bus slave
        st_next.wait_req = ~accept;
        if (accept) begin
            st_next.rdata = avs_read ? read_mux(avs_address, st_reg) : '0;
        end
        if (commit_wr && avs_byteenable[0]) begin
            unique case (avs_address)
                SSWL_OFF_CTRL: begin
                    st_next.dual = avs_writedata[SSWL_CTRL_DUAL];
                    st_next.msg  = avs_writedata[SSWL_CTRL_MSG];
                end
                SSWL_OFF_SLEEP: st_next.sleep = sswl_sleep_e'(avs_writedata[1:0]);
                SSWL_OFF_WAKE:
                    st_next.wake_seen = st_reg.wake_seen & ~avs_writedata[SSWL_WAKE_N-1:0];
                default: ;
            endcase
        end

        // a qualified wake returns to S0 and beats a same-cycle sleep write
        if (|wake_ok) begin
            st_next.sleep = SSWL_S0;
        end
        // set beats clear on the sticky wake causes
        st_next.wake_seen = st_next.wake_seen | wake_ok;

        // blink timebase shared by the power and message lamp and the yellow network lamps
        if (st_reg.blink_cnt >= CNT_W'(BLINK_HALF - 1)) begin
            st_next.blink_cnt = '0;
            st_next.blink_on  = ~st_reg.blink_on;
        end else begin
            st_next.blink_cnt = st_reg.blink_cnt + 1'b1;
        end

        // activity is stretched to whole blink periods so short bursts still show
        st_next.act_seen = st_reg.act_seen | net_activity;
        if (st_reg.blink_cnt >= CNT_W'(BLINK_HALF - 1) && st_reg.blink_on) begin
            st_next.act_show = st_reg.act_seen | net_activity;
            st_next.act_seen = '0;
        end

        // power controls follow the committed state
        st_next.cpu   = (st_next.sleep == SSWL_S0);
        st_next.dev   = (st_next.sleep == SSWL_S0) || (st_next.sleep == SSWL_S1);
        st_next.port  = st_next.dev;
        st_next.wakep = (st_next.sleep != SSWL_S5);

        // power and message lamp; lamp_a is single or green, lamp_b is yellow
        st_next.la = 1'b0;
        st_next.lb = 1'b0;
        unique case (st_next.sleep)
            SSWL_S0: st_next.la = st_next.msg ? st_next.blink_on : 1'b1;
            SSWL_S1: st_next.lb = st_next.dual & (st_next.msg ? st_next.blink_on : 1'b1);
            SSWL_S4: ;
            SSWL_S5: ;
        endcase
        // single lamp has no yellow element and stays dark in S1
        if (!st_next.dual) begin
            st_next.lb = 1'b0;
        end

        // network lamp repeater
        for (int c = 0; c < NUM_CH; c++) begin
            st_next.green[c]  = net_link[c] & net_speed100[c];
            st_next.yellow[c] = net_link[c] &
                                (st_next.act_show[c] ? st_next.blink_on : 1'b1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_reg          <= '0;
            st_reg.sleep    <= SSWL_S0;
            st_reg.dual     <= SSWL_RST_DUAL;
            st_reg.wait_req <= 1'b1;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata    = st_reg.rdata;
    assign avs_waitrequest = st_reg.wait_req;
    assign cpu_run         = st_reg.cpu;
    assign dev_power_en    = st_reg.dev;
    assign port_power_en   = st_reg.port;
    assign wake_power_en   = st_reg.wakep;
    assign lamp_a          = st_reg.la;
    assign lamp_b          = st_reg.lb;
    assign net_led_green   = st_reg.green;
    assign net_led_yellow  = st_reg.yellow;

endmodule
`default_nettype wire

/* sswl_pkg.sv */
// sswl_pkg: constants, types and register map of the sleep-state, wake and lamp block.
// assumes a 100 MHz standby clock and a 32-bit Avalon-MM register slave.
package sswl_pkg;

    typedef enum logic [1:0] {
        SSWL_S0,
        SSWL_S1,
        SSWL_S4,
        SSWL_S5
    } sswl_sleep_e;

    localparam int          SSWL_ADDR_W     = 4;
    localparam logic [3:0]  SSWL_OFF_CTRL   = 4'h0;
    localparam logic [3:0]  SSWL_OFF_SLEEP  = 4'h4;
    localparam logic [3:0]  SSWL_OFF_WAKE   = 4'h8;
    localparam logic [3:0]  SSWL_OFF_LAMP   = 4'hc;

    // control register fields
    localparam int SSWL_CTRL_DUAL  = 0;
    localparam int SSWL_CTRL_MSG   = 1;
    // lamp and power status fields
    localparam int SSWL_LS_LAMP_A  = 0;
    localparam int SSWL_LS_LAMP_B  = 1;
    localparam int SSWL_LS_CPU     = 2;
    localparam int SSWL_LS_DEV     = 3;
    localparam int SSWL_LS_PORT    = 4;
    localparam int SSWL_LS_WAKEP   = 5;
    localparam int SSWL_LS_NET     = 8;

    // wake source bit positions
    localparam int SSWL_WAKE_N     = 7;
    localparam int SSWL_WK_SWITCH  = 0;
    localparam int SSWL_WK_RTC     = 1;
    localparam int SSWL_WK_PME     = 2;
    localparam int SSWL_WK_LAN     = 3;
    localparam int SSWL_WK_IR      = 4;
    localparam int SSWL_WK_KBD     = 5;
    localparam int SSWL_WK_USB     = 6;
    localparam logic [6:0] SSWL_MASK_S1 = 7'h7f;
    localparam logic [6:0] SSWL_MASK_S4 = 7'h07;
    localparam logic [6:0] SSWL_MASK_S5 = 7'h01;

    localparam logic        SSWL_RST_DUAL = 1'b1;
    localparam int          SSWL_CLK_MHZ  = 100;
    localparam int          SSWL_BLINK_HALF_MS = 250;
    localparam int          SSWL_BLINK_HALF_CYC = SSWL_BLINK_HALF_MS * 1000 * SSWL_CLK_MHZ;

endpackage

/* sswl_props.sv */
// sswl_props: port checks for sswl_top.
// assumes clk_en is held high.
`timescale 1ns/1ps
`default_nettype none
module sswl_props #(
    parameter int NUM_CH = 2
) (
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              reset_n,
    // inputs
    input wire logic              avs_write,
    input wire logic              wake_switch,
    input wire logic              wake_rtc_alarm,
    input wire logic              wake_pme,
    input wire logic              wake_usb,
    input wire logic [NUM_CH-1:0] net_link,
    input wire logic [NUM_CH-1:0] net_speed100,
    // outputs
    input wire logic              cpu_run,
    input wire logic              dev_power_en,
    input wire logic              port_power_en,
    input wire logic              wake_power_en,
    input wire logic              lamp_a,
    input wire logic              lamp_b,
    input wire logic [NUM_CH-1:0] net_led_green
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_run_power: assert property (cpu_run |-> dev_power_en && port_power_en)
        else $error("cpu runs unpowered");
    chk_s1_yellow: assert property (lamp_b |-> !cpu_run && dev_power_en)
        else $error("yellow outside sleep");
    chk_unpowered_dark: assert property (!dev_power_en |-> !port_power_en && !lamp_a && !lamp_b)
        else $error("unpowered lamp or port");
    chk_s5_all_off: assert property (!wake_power_en |-> !dev_power_en && !cpu_run)
        else $error("soft off with power");
    chk_s1_usb_wake: assert property (dev_power_en && !cpu_run && wake_usb |=> cpu_run)
        else $error("no wake from usb");
    // a sleep write may legally move the state, so those cycles are skipped
    chk_s4_usb_hold: assert property (!dev_power_en && wake_power_en && !avs_write
        && !(wake_switch || wake_rtc_alarm || wake_pme) |=> !cpu_run)
        else $error("wake from unqualified source");
    chk_s5_switch: assert property ($past(reset_n) && !wake_power_en && wake_switch |=> cpu_run)
        else $error("no wake from switch");
    chk_net_green: assert property ($past(reset_n)
        |-> net_led_green == $past(net_link & net_speed100))
        else $error("green lamp wrong");
endmodule
bind sswl_top sswl_props #(.NUM_CH(NUM_CH)) sswl_props_i (.*);
`default_nettype wire

/* sswl_partner.sv */
// sswl_partner: wake sources that repeat the bench command, one cycle late, until the processor runs.
// assumes the bench commands sources just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module sswl_partner (
    // clock
    input  wire logic       clk_sys,
    // bench command and design state
    input  wire logic [6:0] wake_cmd,
    input  wire logic       cpu_run,
    // wake lines
    output var logic  [6:0] wake_src
);
    initial wake_src = 7'h00;
    // a source is let go once the system is up, as a pressed button is
    always @(posedge clk_sys) begin
        wake_src <= cpu_run ? 7'h00 : wake_cmd;
    end
endmodule
`default_nettype wire

/* sswl_bench.sv */
// sswl_bench: directed bench for sswl_top and the wake model.
// assumes a short blink count so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module sswl_bench
    import sswl_pkg::*;
;
    localparam int BLINK = 8;
    localparam logic [6:0] OKM [4] = '{7'h00, 7'h7f, 7'h07, 7'h01};
    localparam logic [31:0] LS [4] = '{32'h3d, 32'h3a, 32'h20, 32'h00};
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [6:0]  wake_cmd = 7'h00;
    logic [6:0]  wake_src;
    logic        cpu_run, dev_power_en, port_power_en, wake_power_en, lamp_a, lamp_b;
    logic [1:0]  net_link = 2'h0, net_speed100 = 2'h0, net_activity = 2'h0;
    logic [1:0]  net_led_green, net_led_yellow;
    logic [31:0] q;
    int          mismatches = 0;
    int          checks = 0;
    always #5 clk_sys = ~clk_sys;
    sswl_top #(.BLINK_HALF(BLINK)) sswl_top_i (.*, .clk_en(1'b1), .avs_byteenable(4'hf),
        .wake_switch(wake_src[0]), .wake_rtc_alarm(wake_src[1]), .wake_pme(wake_src[2]),
        .wake_lan(wake_src[3]), .wake_ir(wake_src[4]), .wake_kbd_mouse(wake_src[5]),
        .wake_usb(wake_src[6]));
    sswl_partner sswl_partner_i (.clk_sys(clk_sys), .wake_cmd(wake_cmd), .cpu_run(cpu_run),
        .wake_src(wake_src));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one spare edge after release keeps back-to-back calls from double driving
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_address   <= a;
        avs_writedata <= d;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic stop_test;
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // first half period is partial, so only later ones are judged
    task automatic blink(input bit sel);
        int  n;
        logic v;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            v = sel ? lamp_b : lamp_a;
            do begin
                @(posedge clk_sys);
                n++;
            end while ((sel ? lamp_b : lamp_a) === v && n < 100);
            if (k > 0)
                chk("half period", 32'(BLINK), 32'(n));
        end
    endtask
    task automatic t_wake;
        for (int s = 1; s < 4; s++) begin
            for (int b = 0; b < 7; b++) begin
                bus(1'b1, SSWL_OFF_SLEEP, 32'(s));
                bus(1'b0, SSWL_OFF_LAMP, 32'h0);
                chk("status", LS[s], q);
                wake_cmd <= 7'h01 << b;
                repeat (4) @(posedge clk_sys);
                wake_cmd <= 7'h00;
                repeat (3) @(posedge clk_sys);
                bus(1'b0, SSWL_OFF_SLEEP, 32'h0);
                chk("state", OKM[s][b] ? 32'h0 : 32'(s), q);
                bus(1'b0, SSWL_OFF_WAKE, 32'h0);
                chk("cause", {25'h0, OKM[s] & (7'h01 << b)}, q);
                bus(1'b1, SSWL_OFF_WAKE, 32'h7f);
                bus(1'b1, SSWL_OFF_SLEEP, 32'h0);
            end
        end
    endtask
    task automatic t_lamp;
        bus(1'b1, SSWL_OFF_CTRL, 32'h0);
        bus(1'b0, SSWL_OFF_LAMP, 32'h0);
        chk("single s0", 32'h3d, q);
        bus(1'b1, SSWL_OFF_SLEEP, 32'h1);
        bus(1'b0, SSWL_OFF_LAMP, 32'h0);
        chk("single s1", 32'h38, q);
        bus(1'b1, SSWL_OFF_SLEEP, 32'h0);
        bus(1'b1, SSWL_OFF_CTRL, 32'h2);
        blink(1'b0);
        bus(1'b1, SSWL_OFF_CTRL, 32'h3);
        bus(1'b1, SSWL_OFF_SLEEP, 32'h1);
        blink(1'b1);
        bus(1'b1, SSWL_OFF_SLEEP, 32'h0);
    endtask
    task automatic t_net;
        int lo0;
        int lo1;
        lo0 = 0;
        lo1 = 0;
        net_link     <= 2'b11;
        net_speed100 <= 2'b10;
        repeat (3) @(posedge clk_sys);
        chk("green", 32'h2, {30'h0, net_led_green});
        chk("yellow", 32'h3, {30'h0, net_led_yellow});
        net_activity <= 2'b10;
        repeat (6 * BLINK) begin
            @(posedge clk_sys);
            lo0 += !net_led_yellow[0];
            lo1 += !net_led_yellow[1];
        end
        chk("yellow steady", 32'h0, 32'(lo0));
        chk("yellow blinks", 32'h1, 32'(lo1 > 0));
        net_link <= 2'b00;
        repeat (3) @(posedge clk_sys);
        chk("no link", 32'h0, {28'h0, net_led_green, net_led_yellow});
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        bus(1'b0, SSWL_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h1, q);
        bus(1'b0, SSWL_OFF_LAMP, 32'h0);
        chk("status s0", 32'h3d, q);
        t_wake;
        t_lamp;
        t_net;
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        stop_test;
    end
endmodule
`default_nettype wire
